// ==== logic/rrs_alu.sv ====
// rotate-through-overflow and subtract datapath
`timescale 1ns/100ps
`default_nettype none
module rrs_alu (
    input  wire rrs_pkg::rrs_op_t     i_op,  // operation
    input  wire logic [7:0]           i_reg, // addressed register value
    input  wire logic [7:0]           i_acc, // accumulator
    input  wire rrs_pkg::rrs_flags_t  i_fl,  // old status bits
    output var  rrs_pkg::rrs_alu_out_t o_out // result and new status bits
);
    import rrs_pkg::*;

    logic [8:0] diff9;
    logic [4:0] nib5;

    always_comb
    begin
        // two's complement: reg + ~acc + 1, carry out means no borrow
        diff9 = {1'b0, i_reg} + {1'b0, ~i_acc} + 9'h001;      // [RULE7]
        nib5  = {1'b0, i_reg[3:0]} + {1'b0, ~i_acc[3:0]} + 5'h01;
        o_out.res = i_reg;
        o_out.fl  = i_fl;
        case (i_op)
            RRS_ROTATE_LEFT_OP:
            begin
                o_out.res        = {i_reg[6:0], i_fl.ovf_bit}; // [RULE3]
                o_out.fl.ovf_bit = i_reg[7];
            end
            RRS_ROTATE_RIGHT_OP:
            begin
                o_out.res        = {i_fl.ovf_bit, i_reg[7:1]}; // [RULE4]
                o_out.fl.ovf_bit = i_reg[0];
            end
            RRS_SUBTRACT_ACC_FROM_REG_OP:
            begin
                o_out.res                  = diff9[7:0];
                o_out.fl.ovf_bit           = diff9[8];        // [RULE8]
                o_out.fl.nibble_borrow_bit = nib5[4];         // [RULE8]
                o_out.fl.zero_bit          = (diff9[7:0] == 8'h00); // [RULE8]
            end
            default:
            begin
                o_out.res = i_reg;
            end
        endcase
    end
endmodule
`default_nettype wire

// ==== logic/rrs_core.sv ====
// return/rotate/subtract execution unit with a classic Wishbone register slave
`timescale 1ns/100ps
`default_nettype none
`include "rrs_defines.svh"

//Contract
// RULE1: A return pops the stack and loads the popped top entry into the PC, leaving status alone.
// RULE2: A return occupies two instruction cycles, the second being a discarded fetch.
// RULE3: Rotate left moves the old overflow bit into bit 0 and old bit 7 into the overflow bit only.
// RULE4: Rotate right moves the old overflow bit into bit 7 and old bit 0 into the overflow bit only.
// RULE5: Rotate and subtract results go to the accumulator when the target bit is 0, else to the register.
// RULE6: The register index is a 7-bit field for 0 to 127 and the target select is one bit.
// RULE7: Subtract computes register minus accumulator by adding the negated accumulator.
// RULE8: Subtract sets overflow when acc <= reg, nibble borrow when acc low nibble <= reg's, zero on 0.
module rrs_core #(
    parameter int STACK_DEPTH = 8
) (
    input  wire logic                I_CLK,    // core clock, 50 MHz
    input  wire logic                I_RESETN, // synchronous reset, active low
    input  wire rrs_pkg::rrs_wb_req_t I_WB,    // Wishbone request
    output var  rrs_pkg::rrs_wb_rsp_t O_WB,    // Wishbone answer
    output var  logic                O_BUSY    // an operation is executing
);
    import rrs_pkg::*;

    localparam int PW = $clog2(STACK_DEPTH);

    if (STACK_DEPTH < 2 || (1 << PW) != STACK_DEPTH)
    begin : g_chk
        $error("rrs_core: STACK_DEPTH must be a power of two, at least 2");
    end

    typedef struct packed {
        rrs_state_t                   st;
        logic [STACK_DEPTH-1:0][12:0] stk;
        logic [PW-1:0]                sp;
        logic [12:0]                  pc;
        logic [7:0]                   acc;
        rrs_flags_t                   fl;
        rrs_op_t                      op;
        logic                         d;
        logic [6:0]                   fidx;
        logic [6:0]                   faddr;
        logic                         pend;
        logic                         ack;
        logic [31:0]                  dat;
    } rrs_core_t;

    rrs_core_t    q;
    rrs_core_t    n;
    rrs_alu_out_t alu;
    logic         mem_we;
    logic [6:0]   mem_addr;
    logic [7:0]   mem_wdata;
    logic [7:0]   mem_rdata;
    logic [PW-1:0] top_idx;
    logic [12:0]  top_val;
    logic         wr_ok;

    assign top_idx = q.sp - PW'(1);
    assign top_val = q.stk[top_idx];
    // partial byte-lane writes are ignored: every field spans its own lanes
    assign wr_ok   = q.pend && I_WB.we && (I_WB.sel == `RRS_SEL_ALL);

    rrs_regfile #(
        .AW (7),
        .DW (8)
    ) u_rf (
        .i_clk   (I_CLK),
        .i_we    (mem_we),
        .i_addr  (mem_addr),
        .i_wdata (mem_wdata),
        .o_rdata (mem_rdata)
    );

    rrs_alu u_alu (
        .i_op  (q.op),
        .i_reg (mem_rdata),
        .i_acc (q.acc),
        .i_fl  (q.fl),
        .o_out (alu)
    );

    always_comb
    begin
        n         = q;
        mem_we    = 1'b0;
        mem_addr  = q.faddr;
        mem_wdata = I_WB.dat[7:0];
        n.ack     = 1'b0;
        // bus only served while idle, so it never fights the datapath for memory
        n.pend    = I_WB.cyc && I_WB.stb && !q.pend && !q.ack && (q.st == S_IDLE);

        if (q.pend)
        begin
            n.ack = 1'b1;
            n.dat = 32'h0000_0000;
            if (I_WB.adr == `RRS_ADR_CTRL)
            begin
                n.dat[`RRS_CTRL_OP_LSB +: 2] = q.op;
                n.dat[`RRS_CTRL_D_BIT]       = q.d;
                n.dat[`RRS_CTRL_F_LSB +: 7]  = q.fidx;
            end
            else if (I_WB.adr == `RRS_ADR_ACC)
            begin
                n.dat[7:0] = q.acc;
            end
            else if (I_WB.adr == `RRS_ADR_STAT)
            begin
                n.dat[2:0] = q.fl;
            end
            else if (I_WB.adr == `RRS_ADR_PC)
            begin
                n.dat[12:0] = q.pc;
            end
            else if (I_WB.adr == `RRS_ADR_STACK)
            begin
                n.dat[PW-1:0] = q.sp;
            end
            else if (I_WB.adr == `RRS_ADR_FADDR)
            begin
                n.dat[6:0] = q.faddr;
            end
            else if (I_WB.adr == `RRS_ADR_FDATA)
            begin
                n.dat[7:0] = mem_rdata;
            end
        end

        if (wr_ok)
        begin
            if (I_WB.adr == `RRS_ADR_CTRL)
            begin
                n.op   = rrs_op_t'(I_WB.dat[`RRS_CTRL_OP_LSB +: 2]);
                n.d    = I_WB.dat[`RRS_CTRL_D_BIT];
                n.fidx = I_WB.dat[`RRS_CTRL_F_LSB +: 7]; // [RULE6]
                if (I_WB.dat[`RRS_CTRL_GO_BIT])
                begin
                    if (rrs_op_t'(I_WB.dat[`RRS_CTRL_OP_LSB +: 2]) == RRS_RETURN_OP)
                    begin
                        n.st = S_RET1;
                    end
                    else
                    begin
                        n.st = S_READ;
                    end
                end
            end
            else if (I_WB.adr == `RRS_ADR_ACC)
            begin
                n.acc = I_WB.dat[7:0];
            end
            else if (I_WB.adr == `RRS_ADR_STAT)
            begin
                n.fl = rrs_flags_t'(I_WB.dat[2:0]);
            end
            else if (I_WB.adr == `RRS_ADR_PC)
            begin
                n.pc = I_WB.dat[12:0];
            end
            else if (I_WB.adr == `RRS_ADR_STACK)
            begin
                // circular stack: a push past the depth overwrites the oldest
                n.stk[q.sp] = I_WB.dat[12:0];
                n.sp        = q.sp + PW'(1);
            end
            else if (I_WB.adr == `RRS_ADR_FADDR)
            begin
                n.faddr = I_WB.dat[6:0];
            end
            else if (I_WB.adr == `RRS_ADR_FDATA)
            begin
                mem_we = 1'b1;
            end
        end

        case (q.st)
            S_IDLE:
            begin
                n.st = n.st;
            end
            S_READ:
            begin
                mem_addr = q.fidx;                       // [RULE6]
                n.st     = S_EXEC;
            end
            S_EXEC:
            begin
                mem_addr = q.fidx;
                n.fl     = alu.fl;                       // [RULE8]
                if (q.d)
                begin
                    mem_we    = 1'b1;                    // [RULE5]
                    mem_wdata = alu.res;
                end
                else
                begin
                    n.acc = alu.res;                     // [RULE5]
                end
                n.st = S_IDLE;
            end
            S_RET1:
            begin
                n.pc = top_val;                          // [RULE1]
                n.sp = top_idx;
                n.st = S_RET2;                           // [RULE2]
            end
            S_RET2:
            begin
                // slot of the fetch that is thrown away after the reload
                n.st = S_IDLE;                           // [RULE2]
            end
            default:
            begin
                n.st = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_RESETN)
        begin
            q     <= '0;
            q.st  <= S_IDLE;
            q.acc <= `RRS_ACC_RST;
            q.pc  <= `RRS_PC_RST;
            q.fl  <= `RRS_STAT_RST;
        end
        else
        begin
            q <= n;
        end
    end

    assign O_WB   = '{ack: q.ack, dat: q.dat};
    assign O_BUSY = (q.st != S_IDLE);

    // checker helpers
    logic [8:0]  rl_exp;
    logic [8:0]  rr_exp;
    logic [7:0]  sub_diff;
    logic [10:0] sub_exp;

    assign rl_exp   = {mem_rdata, q.fl.ovf_bit};
    assign rr_exp   = {q.fl.ovf_bit, mem_rdata};
    assign sub_diff = mem_rdata - q.acc;
    assign sub_exp  = {(sub_diff == 8'h00), (q.acc[3:0] <= mem_rdata[3:0]),
                       (q.acc <= mem_rdata), sub_diff};

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RESETN);

    sequence s_ret_walk;
        (q.st == S_RET1) ##1 (q.st == S_RET2) ##1 (q.st == S_IDLE);
    endsequence

    property p_ret_pc;
        (q.st == S_RET1) |=> (q.pc == $past(top_val)) && (q.sp == $past(top_idx)) && $stable(q.fl);
    endproperty
    a_ret_pc: assert property (p_ret_pc) else $error("return did not load stack top"); // [RULE1]

    property p_ret_len;
        (q.st == S_RET1) |-> s_ret_walk;
    endproperty
    a_ret_len: assert property (p_ret_len) else $error("return not two cycles"); // [RULE2]

    property p_rl;
        (q.st == S_EXEC && q.op == RRS_ROTATE_LEFT_OP && !q.d)
            |=> ({q.fl.ovf_bit, q.acc} == $past(rl_exp));
    endproperty
    a_rl: assert property (p_rl) else $error("rotate left result wrong"); // [RULE3]

    property p_rot_keep;
        (q.st == S_EXEC && (q.op == RRS_ROTATE_LEFT_OP || q.op == RRS_ROTATE_RIGHT_OP))
            |=> $stable(q.fl.zero_bit) && $stable(q.fl.nibble_borrow_bit);
    endproperty
    a_rot_keep: assert property (p_rot_keep) else $error("rotate touched other status"); // [RULE3]

    property p_rr;
        (q.st == S_EXEC && q.op == RRS_ROTATE_RIGHT_OP && !q.d)
            |=> ({q.acc, q.fl.ovf_bit} == $past(rr_exp));
    endproperty
    a_rr: assert property (p_rr) else $error("rotate right result wrong"); // [RULE4]

    property p_dest;
        (q.st == S_EXEC && q.d) |-> (mem_we && mem_addr == q.fidx && mem_wdata == alu.res)
            ##1 $stable(q.acc);
    endproperty
    a_dest: assert property (p_dest) else $error("register target not honoured"); // [RULE5]

    property p_idx;
        (q.st == S_READ) |-> (mem_addr == q.fidx) && !mem_we ##1 (q.st == S_EXEC);
    endproperty
    a_idx: assert property (p_idx) else $error("wrong register index used"); // [RULE6]

    property p_sub_res;
        (q.st == S_EXEC && q.op == RRS_SUBTRACT_ACC_FROM_REG_OP && !q.d)
            |=> (q.acc == $past(sub_diff));
    endproperty
    a_sub_res: assert property (p_sub_res) else $error("subtract result wrong"); // [RULE7]

    property p_sub_fl;
        (q.st == S_EXEC && q.op == RRS_SUBTRACT_ACC_FROM_REG_OP)
            |=> ({q.fl, 8'h00} == {$past(sub_exp[10:8]), 8'h00});
    endproperty
    a_sub_fl: assert property (p_sub_fl) else $error("subtract status wrong"); // [RULE8]

endmodule
`default_nettype wire

// ==== logic/rrs_defines.svh ====
// register offsets, field positions and reset values of the rotate/subtract/return block
`ifndef RRS_DEFINES_SVH
`define RRS_DEFINES_SVH

`define RRS_ADR_CTRL      8'h00
`define RRS_ADR_ACC       8'h04
`define RRS_ADR_STAT      8'h08
`define RRS_ADR_PC        8'h0C
`define RRS_ADR_STACK     8'h10
`define RRS_ADR_FADDR     8'h14
`define RRS_ADR_FDATA     8'h18

`define RRS_CTRL_OP_LSB   0
`define RRS_CTRL_D_BIT    2
`define RRS_CTRL_F_LSB    8
`define RRS_CTRL_GO_BIT   31

`define RRS_ACC_RST       8'h00
`define RRS_PC_RST        13'h0000
`define RRS_STAT_RST      3'h0
`define RRS_SEL_ALL       4'hF

`endif

// ==== logic/rrs_pkg.sv ====
// types shared by the rotate/subtract/return block
package rrs_pkg;

    typedef enum logic [1:0] {
        RRS_RETURN_OP            = 2'h0,
        RRS_ROTATE_LEFT_OP       = 2'h1,
        RRS_ROTATE_RIGHT_OP      = 2'h2,
        RRS_SUBTRACT_ACC_FROM_REG_OP = 2'h3
    } rrs_op_t;

    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_READ = 5'h02,
        S_EXEC = 5'h04,
        S_RET1 = 5'h08,
        S_RET2 = 5'h10
    } rrs_state_t;

    typedef struct packed {
        logic zero_bit;
        logic nibble_borrow_bit;
        logic ovf_bit;
    } rrs_flags_t;

    typedef struct packed {
        logic [7:0] res;
        rrs_flags_t fl;
    } rrs_alu_out_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } rrs_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } rrs_wb_rsp_t;

endpackage

// ==== logic/rrs_regfile.sv ====
// file register memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module rrs_regfile #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    input  wire logic          i_clk,   // core clock
    input  wire logic          i_we,    // write strobe
    input  wire logic [AW-1:0] i_addr,  // word index
    input  wire logic [DW-1:0] i_wdata, // write data
    output var  logic [DW-1:0] o_rdata  // data of last cycle's address
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    if (AW < 1 || DW < 1)
    begin : g_chk
        $error("rrs_regfile: bad geometry");
    end

    // write-first is not needed: data read in a write cycle is never used
    always_ff @(posedge i_clk)
    begin
        if (i_we)
        begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// register-level testbench of the return/rotate/subtract execution unit
`timescale 1ns/100ps
`default_nettype none
`include "rrs_defines.svh"
module tb;
    import rrs_pkg::*;

    logic        clk      = 1'b0;
    logic        resetn   = 1'b0;
    rrs_wb_req_t wb       = '0;
    rrs_wb_rsp_t rsp;
    logic        busy;
    int          errors   = 0;
    int          n_checks = 0;
    logic [31:0] q;
    logic [7:0]  t_r   [4] = '{8'h05, 8'h03, 8'h3A, 8'hF7};
    logic [7:0]  t_a   [4] = '{8'h05, 8'h05, 8'h12, 8'h08};
    logic [7:0]  t_res [4] = '{8'h00, 8'hFE, 8'h28, 8'hEF};
    logic [2:0]  t_st  [4] = '{3'h7, 3'h0, 3'h3, 3'h1};

    always #10 clk = ~clk;

    rrs_core #(
        .STACK_DEPTH (8)
    ) dut_u (
        .I_CLK    (clk),
        .I_RESETN (resetn),
        .I_WB     (wb),
        .O_WB     (rsp),
        .O_BUSY   (busy)
    );

    task automatic results();
        $display("checks %0d, mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one classic cycle; ack and data are taken at the same rising edge
    task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                       input logic [31:0] d, output logic [31:0] rq);
        int n;
        n = 0;
        @(posedge clk);
        wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: d};
        do
        begin
            @(posedge clk);
            n++;
        end while (rsp.ack !== 1'b1 && n < 50);
        rq = rsp.dat;
        wb <= '0;
        if (n >= 50)
        begin
            errors++;
            $display("MISMATCH ack expected 1 seen none");
        end
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, adr, `RRS_SEL_ALL, d, dummy);
    endtask

    task automatic rd(input logic [7:0] adr, output logic [31:0] rq);
        bus(1'b0, adr, `RRS_SEL_ALL, 32'h0, rq);
    endtask

    function automatic logic [31:0] ctrl(input rrs_op_t op, input logic d, input logic [6:0] f);
        return {1'b1, 16'h0, f, 5'h0, d, op};
    endfunction

    // start an op and count the cycles it keeps the unit busy
    task automatic run_op(input logic [31:0] c);
        int n;
        wr(`RRS_ADR_CTRL, c);
        n = 0;
        while (busy === 1'b1 && n < 10)
        begin
            @(posedge clk);
            n++;
        end
        check("busy cycles", 32'd2, n);
    endtask

    initial
    begin
        repeat (2000) @(posedge clk);
        errors++;
        $display("MISMATCH watchdog expected done seen hang");
        results();
    end

    initial
    begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        rd(`RRS_ADR_ACC, q);
        check("acc reset", 32'h0, q);
        rd(`RRS_ADR_PC, q);
        check("pc reset", 32'h0, q);
        rd(`RRS_ADR_STAT, q);
        check("status reset", 32'h0, q);
        rd(8'h1C, q);
        check("unmapped read", 32'h0, q);
        // partial-select write must be dropped
        bus(1'b1, `RRS_ADR_ACC, 4'h3, 32'h5A, q);
        rd(`RRS_ADR_ACC, q);
        check("acc after narrow write", 32'h0, q);
        // return pops newest entry first, status left alone
        wr(`RRS_ADR_STAT, 32'h5);
        wr(`RRS_ADR_STACK, 32'h0ABC);
        wr(`RRS_ADR_STACK, 32'h1234);
        run_op(ctrl(RRS_RETURN_OP, 1'b0, 7'h0));
        rd(`RRS_ADR_PC, q);
        check("pc after return", 32'h1234, q);
        rd(`RRS_ADR_STACK, q);
        check("stack pointer", 32'h1, q);
        run_op(ctrl(RRS_RETURN_OP, 1'b0, 7'h0));
        rd(`RRS_ADR_PC, q);
        check("pc after 2nd return", 32'h0ABC, q);
        rd(`RRS_ADR_STAT, q);
        check("status after return", 32'h5, q);
        // rotate left into accumulator, nibble borrow and zero kept
        wr(`RRS_ADR_FADDR, 32'h5);
        wr(`RRS_ADR_FDATA, 32'hE6);
        wr(`RRS_ADR_STAT, 32'h6);
        run_op(ctrl(RRS_ROTATE_LEFT_OP, 1'b0, 7'h05));
        rd(`RRS_ADR_ACC, q);
        check("rotl acc", 32'hCC, q);
        rd(`RRS_ADR_STAT, q);
        check("rotl status", 32'h7, q);
        rd(`RRS_ADR_FDATA, q);
        check("rotl file kept", 32'hE6, q);
        // rotate right back into the top register index
        wr(`RRS_ADR_FADDR, 32'h7F);
        wr(`RRS_ADR_FDATA, 32'h02);
        wr(`RRS_ADR_STAT, 32'h1);
        run_op(ctrl(RRS_ROTATE_RIGHT_OP, 1'b1, 7'h7F));
        rd(`RRS_ADR_FDATA, q);
        check("rotr file", 32'h81, q);
        rd(`RRS_ADR_STAT, q);
        check("rotr status", 32'h0, q);
        rd(`RRS_ADR_ACC, q);
        check("rotr acc kept", 32'hCC, q);
        // operand fields read back, start bit not kept
        rd(`RRS_ADR_CTRL, q);
        check("ctrl readback", 32'h0000_7F06, q);
        rd(`RRS_ADR_FADDR, q);
        check("faddr readback", 32'h7F, q);
        // subtract table, odd entries to the accumulator
        for (int i = 0; i < 4; i++)
        begin
            wr(`RRS_ADR_FADDR, 32'(i * 40 + 3));
            wr(`RRS_ADR_FDATA, {24'h0, t_r[i]});
            wr(`RRS_ADR_ACC, {24'h0, t_a[i]});
            wr(`RRS_ADR_STAT, {29'h0, ~t_st[i]});
            run_op(ctrl(RRS_SUBTRACT_ACC_FROM_REG_OP, ~i[0], 7'(i * 40 + 3)));
            rd(`RRS_ADR_FDATA, q);
            check("sub file", {24'h0, i[0] ? t_r[i] : t_res[i]}, q);
            rd(`RRS_ADR_ACC, q);
            check("sub acc", {24'h0, i[0] ? t_res[i] : t_a[i]}, q);
            rd(`RRS_ADR_STAT, q);
            check("sub status", {29'h0, t_st[i]}, q);
        end
        results();
    end
endmodule
`default_nettype wire
